//--- dv/host_port_model.sv
/*
 * Host model: issues one-cycle register strobes on the falling edge.
 * Assumes a free-running i_clk and registered read data.
 */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output var logic [7:0] o_addr,
	output var logic [7:0] o_wdata,
	output var logic o_write,
	output var logic o_read
);
	// Idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_wdata = 8'h00;
		o_write = 1'b0;
		o_read = 1'b0;
	end
	// Released lines show inverted values so stale data is not trusted
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wdata = d;
		o_write = 1'b1;
		@(negedge i_clk);
		o_write = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_read = 1'b1;
		@(negedge i_clk);
		o_read = 1'b0;
		o_addr = ~a;
		@(negedge i_clk);
		d = i_rdata;
	endtask
	// Both lock flags up and no frequency loss
	function automatic logic pll_healthy(input logic [7:0] f);
		return f[3] & f[1] & ~f[4];
	endfunction
endmodule // host_port_model
`default_nettype wire

//--- dv/status_flag_bank_properties.sv
/*
 * Port assertions for the status and configuration register bank.
 * Assumes it is bound onto the bank's top module, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module status_flag_bank_properties #(
	parameter COUNT_WIDTH = 9,
	parameter [7:0] DEVICE_ID = 8'h5A
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_write,
	input wire logic i_reg_read,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [COUNT_WIDTH-1:0] i_fifo_count,
	input wire logic i_fifo_new_word,
	input wire logic i_pll_freq_locked,
	input wire logic i_undervoltage,
	input wire logic [7:0] o_almost_full_threshold,
	input wire logic [7:0] o_irq_mask_primary,
	input wire logic o_fifo_data_read,
	input wire logic o_irq_pin
);
	// One clock, one reset for every check
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_id_read: assert property (i_reg_read && i_reg_addr == 8'hFF
		|-> ##1 o_reg_rdata == DEVICE_ID) else $error("bad id");
	a_hole_zero: assert property (i_reg_read && i_reg_addr == 8'h05
		|-> ##1 o_reg_rdata == 8'h00) else $error("hole not zero");
	a_gap_bit: assert property (i_reg_read && i_reg_addr == 8'h00
		|-> ##1 !o_reg_rdata[6]) else $error("bit six set");
	a_data_strobe: assert property (
		o_fifo_data_read == (i_reg_read && i_reg_addr == 8'h0C))
		else $error("data read strobe wrong");
	a_limit_write: assert property (
		i_reg_write && i_reg_addr == 8'h0D
		|=> o_almost_full_threshold == $past(i_reg_wdata))
		else $error("threshold not written");
	a_full_irq: assert property (
		(o_irq_mask_primary[7] && i_fifo_count >= o_almost_full_threshold)[*2]
		|-> ##[0:3] o_irq_pin) else $error("almost full no irq");
	a_sample_irq: assert property (
		o_irq_mask_primary[5] && i_fifo_new_word |-> ##[1:3] o_irq_pin)
		else $error("new sample no irq");
	a_lock_irq: assert property (
		(o_irq_mask_primary[3] && i_pll_freq_locked)[*5]
		|-> o_irq_pin) else $error("lock no irq");
	a_uv_irq: assert property ($rose(i_undervoltage)
		|-> ##[1:8] o_irq_pin) else $error("undervoltage no irq");
endmodule // status_flag_bank_properties
`default_nettype wire

//--- dv/status_flag_register_bank_bench.sv
/*
 * Self-checking bench for the register bank with a host model.
 * Assumes the bank answers reads one cycle after the strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module status_flag_register_bank_bench;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary value
	logic i_clk = 1'b0, i_reset_n = 1'b0, new_word = 1'b0;
	logic pll_freq_acquired_flag = 1'b0, phase_lock = 1'b0, uv = 1'b0;
	logic [8:0] fifo_count = 9'h000;
	logic [7:0] st_err = 8'h96, fifo_rdata = 8'hC3, v, sec = 8'h00;
	logic [7:0] cfg [0:15] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
		8'h28, 8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h58, 8'h81, 8'h0D, 8'h11};
	wire [7:0] addr, wdata, rdata;
	wire wr, rd, irq;
	int miscompares = 0, checks_done = 0, cycles = 0;
	always #12.5 i_clk = ~i_clk;
	host_port_model host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
		.o_wdata(wdata), .o_write(wr), .o_read(rd));
	status_flag_register_bank #(.DEVICE_ID(ID)) dut (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata),
		.i_fifo_count(fifo_count), .i_fifo_new_word(new_word),
		.i_fifo_rdata(fifo_rdata), .i_pll_freq_locked(pll_freq_acquired_flag),
		.i_pll_phase_locked(phase_lock), .i_undervoltage(uv),
		.i_self_test_error(st_err), .i_secondary_flags(sec),
		.o_almost_full_threshold(), .o_fifo_config(), .o_system_config(),
		.o_impedance_config_3(), .o_impedance_config_4(),
		.o_impedance_config_5(), .o_impedance_config_6(),
		.o_reading_low_limit(), .o_reading_high_limit(),
		.o_impedance_config_7(), .o_electrode_switch_config_1(),
		.o_electrode_switch_config_2(), .o_electrode_assignment(),
		.o_lead_detect_config(), .o_lead_detect_limit(),
		.o_lead_bias_config(), .o_irq_mask_primary(),
		.o_irq_mask_secondary(), .o_fifo_data_read(), .o_irq_pin(irq));
	// Compare and count
	task check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.read_reg(a, v);
		check(v, e);
	endtask
	task waitn(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task t_reset;
		check({7'h00, irq}, 8'h01);
		rd_chk(8'h00, 8'h81);
		rd_chk(8'h00, 8'h80);
		check({7'h00, irq}, 8'h00);
		rd_chk(8'hFF, ID);
		rd_chk(8'h05, 8'h00);
	endtask
	// Reset value, write, readback; read-only place keeps its input
	task t_regs;
		for (int i = 0; i < 16; i++) begin
			rd_chk(cfg[i], 8'h00);
			host.write_reg(cfg[i], cfg[i] ^ 8'h5A);
			rd_chk(cfg[i], cfg[i] ^ 8'h5A);
		end
		host.write_reg(8'h11, 8'h00);
		host.write_reg(8'h44, 8'hFF);
		rd_chk(8'h44, 8'h96);
		// Second bank: bit 2 masked off, bit 0 enabled by 0xDB
		sec = 8'h04;
		waitn(4);
		check({7'h00, irq}, 8'h00);
		sec = 8'h01;
		waitn(4);
		check({7'h00, irq}, 8'h01);
		sec = 8'h00;
		waitn(4);
		check({7'h00, irq}, 8'h00);
	endtask
	task t_full;
		host.write_reg(8'h0D, 8'h04);
		rd_chk(8'h00, 8'h80);
		host.write_reg(8'h80, 8'h80);
		fifo_count = 9'h003;
		waitn(3);
		rd_chk(8'h00, 8'h00);
		fifo_count = 9'h004;
		waitn(3);
		check({7'h00, irq}, 8'h01);
		fifo_count = 9'h000;
		rd_chk(8'h0C, 8'hC3);
		rd_chk(8'h00, 8'h80);
		rd_chk(8'h00, 8'h00);
		host.write_reg(8'h80, 8'h20);
		host.write_reg(8'h0E, 8'h08);
		fifo_count = 9'h004;
		new_word = 1'b1;
		waitn(1);
		new_word = 1'b0;
		waitn(3);
		check({7'h00, irq}, 8'h01);
		fifo_count = 9'h000;
		rd_chk(8'h0C, 8'hC3);
		rd_chk(8'h00, 8'h00);
		new_word = 1'b1;
		waitn(1);
		new_word = 1'b0;
		rd_chk(8'h00, 8'h20);
		check({7'h00, irq}, 8'h00);
		host.write_reg(8'h0E, 8'h00);
		host.write_reg(8'h80, 8'h00);
	endtask
	task t_uv;
		uv = 1'b1;
		waitn(6);
		check({7'h00, irq}, 8'h01);
		rd_chk(8'h00, 8'h01);
		uv = 1'b0;
		waitn(4);
		uv = 1'b1;
		waitn(6);
		host.write_reg(8'h11, 8'h02);
		waitn(2);
		check({7'h00, irq}, 8'h00);
		rd_chk(8'h00, 8'h00);
		host.write_reg(8'h11, 8'h00);
	endtask
	task t_pll;
		host.write_reg(8'h80, 8'h08);
		pll_freq_acquired_flag = 1'b1;
		phase_lock = 1'b1;
		waitn(6);
		rd_chk(8'h00, 8'h0A);
		check({7'h00, host.pll_healthy(v)}, 8'h01);
		rd_chk(8'h00, 8'h0A);
		phase_lock = 1'b0;
		waitn(6);
		rd_chk(8'h00, 8'h0E);
		rd_chk(8'h00, 8'h0C);
		pll_freq_acquired_flag = 1'b0;
		waitn(6);
		rd_chk(8'h00, 8'h1C);
		rd_chk(8'h00, 8'h10);
		check({7'h00, host.pll_healthy(v)}, 8'h00);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		waitn(16);
		i_reset_n = 1'b1;
		waitn(1);
		t_reset;
		t_regs;
		t_full;
		t_uv;
		t_pll;
		conclude;
	end
endmodule // status_flag_register_bank_bench
bind status_flag_register_bank status_flag_bank_properties #(
	.COUNT_WIDTH(COUNT_WIDTH), .DEVICE_ID(DEVICE_ID)) chk (.i_clk(i_clk),
	.i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
	.i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
	.i_fifo_count(i_fifo_count), .i_fifo_new_word(i_fifo_new_word),
	.i_pll_freq_locked(i_pll_freq_locked), .i_undervoltage(i_undervoltage),
	.o_almost_full_threshold(o_almost_full_threshold),
	.o_irq_mask_primary(o_irq_mask_primary),
	.o_fifo_data_read(o_fifo_data_read), .o_irq_pin(o_irq_pin));
`default_nettype wire

//--- logic/status_flag_cell.v
/*
 * One sticky status flag: set by a hardware event, cleared by a
 * read strobe. Set wins over clear in the same cycle.
 * Assumes event and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module status_flag_cell #(
	parameter RESET_VALUE = 1'b0
) (
	input wire i_clk,
	input wire i_reset_n,
	input wire i_set,
	input wire i_clear,
	output reg o_flag
);

	// Set dominates so no event falls into a clearing read
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_flag <= RESET_VALUE;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_clear) begin
			o_flag <= 1'b0;
		end
	end

endmodule // status_flag_cell

`default_nettype wire

//--- logic/status_flag_register_bank.v
/*
 * Register bank of the impedance front end: configuration,
 * electrode switch, lead detect, lead bias, interrupt enable and
 * identifier registers, plus the first status register with its
 * clear-on-read flags and the interrupt pin.
 * Assumes the serial port decodes transfers into one-cycle read and
 * write strobes with address on i_clk, FIFO level likewise; PLL lock and
 * undervoltage indications arrive from outside the clock domain.
 */
// Notes on behaviour
// - Almost-full flag sets once the FIFO count reaches the threshold.
// - Almost-full clears on a status read, or a data read if enabled.
// - New-sample flag sets when a new word enters the FIFO.
// - New-sample clears on a status read, or a data read if enabled.
// - Frequency-loss flag sets on unlock, again while unlock lasts.
// - Frequency-acquired flag stays asserted while lock is held.
// - Phase-loss flag sets only after phase lock was held then lost.
// - Phase-acquired flag sets on lock and again while lock lasts.
// - Undervoltage flag is unmaskable, cleared by read or shutdown.
`timescale 1ns/1ps
`default_nettype none
`include "flag_bank_regs.vh"

module status_flag_register_bank #(
	parameter COUNT_WIDTH = 9,
	parameter [7:0] DEVICE_ID = 8'h5A // Arbitrary value
) (
	input wire i_clk,
	input wire i_reset_n,
	// Register port from the serial control logic
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_write,
	input wire i_reg_read,
	output reg [7:0] o_reg_rdata,
	// FIFO state
	input wire [COUNT_WIDTH-1:0] i_fifo_count,
	input wire i_fifo_new_word,
	input wire [7:0] i_fifo_rdata,
	// Asynchronous indications
	input wire i_pll_freq_locked,
	input wire i_pll_phase_locked,
	input wire i_undervoltage,
	input wire [7:0] i_self_test_error,
	input wire [7:0] i_secondary_flags,
	// Configuration outputs
	output reg [7:0] o_almost_full_threshold,
	output reg [7:0] o_fifo_config,
	output reg [7:0] o_system_config,
	output reg [7:0] o_impedance_config_3,
	output reg [7:0] o_impedance_config_4,
	output reg [7:0] o_impedance_config_5,
	output reg [7:0] o_impedance_config_6,
	output reg [7:0] o_reading_low_limit,
	output reg [7:0] o_reading_high_limit,
	output reg [7:0] o_impedance_config_7,
	output reg [7:0] o_electrode_switch_config_1,
	output reg [7:0] o_electrode_switch_config_2,
	output reg [7:0] o_electrode_assignment,
	output reg [7:0] o_lead_detect_config,
	output reg [7:0] o_lead_detect_limit,
	output reg [7:0] o_lead_bias_config,
	output reg [7:0] o_irq_mask_primary,
	output reg [7:0] o_irq_mask_secondary,
	output wire o_fifo_data_read,
	output reg o_irq_pin
);

	// Two-flop synchronisers for the asynchronous levels
	reg [2:0] sync_meta;
	reg [2:0] sync_level;
	reg [7:0] sec_meta;
	reg [7:0] sec_flags;
	reg [7:0] test_meta;
	reg [7:0] test_err;

	// Self-test result is quasi-static but still crosses domains
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_meta <= 3'h0;
			sync_level <= 3'h0;
			sec_meta <= 8'h00;
			sec_flags <= 8'h00;
			test_meta <= 8'h00;
			test_err <= 8'h00;
		end else begin
			sync_meta <= {i_undervoltage, i_pll_phase_locked,
				i_pll_freq_locked};
			sync_level <= sync_meta;
			sec_meta <= i_secondary_flags;
			sec_flags <= sec_meta;
			test_meta <= i_self_test_error;
			test_err <= test_meta;
		end
	end

	wire freq_locked;
	wire phase_locked;
	wire undervoltage;
	assign freq_locked = sync_level[0];
	assign phase_locked = sync_level[1];
	assign undervoltage = sync_level[2];

	// Previous values for edge detection
	reg freq_locked_d;
	reg phase_locked_d;
	reg undervoltage_d;
	reg phase_was_locked;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			freq_locked_d <= 1'b0;
			phase_locked_d <= 1'b0;
			undervoltage_d <= 1'b0;
			phase_was_locked <= 1'b0;
		end else begin
			freq_locked_d <= freq_locked;
			phase_locked_d <= phase_locked;
			undervoltage_d <= undervoltage;
			// Remember a held phase lock until frequency lock drops
			if (phase_locked) begin
				phase_was_locked <= 1'b1;
			end else if (!freq_locked) begin
				phase_was_locked <= 1'b0;
			end
		end
	end

	// Address decode helper used for reads and writes
	// One function keeps read and write decode identical
	function is_addr;
		input [7:0] addr;
		input [7:0] target;
		begin
			is_addr = (addr == target);
		end
	endfunction

	wire status_read;
	wire data_read;
	wire data_read_clear;
	wire shutdown_set;
	// Clear strobes come straight from the decoded read, or from the decoded shutdown write
	assign status_read = i_reg_read &&
		is_addr(i_reg_addr, `ADDR_EVENT_FLAGS_PRIMARY);
	assign data_read = i_reg_read &&
		is_addr(i_reg_addr, `ADDR_FIFO_DATA);
	assign data_read_clear = data_read &&
		o_fifo_config[`BIT_FLAG_CLEAR_ON_DATA_READ];
	assign shutdown_set = i_reg_write &&
		is_addr(i_reg_addr, `ADDR_SYSTEM_CONFIG_1) &&
		i_reg_wdata[`BIT_SHUTDOWN_CONTROL];
	// Pop strobe; the byte is captured at the same edge
	assign o_fifo_data_read = data_read;

	// Almost-full is level-triggered on the threshold comparison
	// Limitation: threshold zero counts an empty FIFO as reached
	wire almost_full_reached;
	assign almost_full_reached = (i_fifo_count >=
		{{(COUNT_WIDTH-8){1'b0}}, o_almost_full_threshold});

	// Frequency loss persists only after a lock was ever seen
	// Without this memory an unlocked PLL at power-up would flag loss
	reg freq_ever_locked;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			freq_ever_locked <= 1'b0;
		end else if (freq_locked) begin
			freq_ever_locked <= 1'b1;
		end
	end

	// Set and clear terms for each flag
	wire [7:0] flag_set;
	wire [7:0] flag_clear;
	localparam [7:0] FLAG_RESET = `RESET_EVENT_FLAGS;
	wire [7:0] event_flags;

	assign flag_set[`BIT_ALMOST_FULL] = almost_full_reached;
	assign flag_set[6] = 1'b0;
	assign flag_set[`BIT_NEW_SAMPLE] = i_fifo_new_word;
	// Loss and lock flags re-set while the state persists
	assign flag_set[`BIT_FREQ_LOSS] = !freq_locked &&
		(freq_locked_d || freq_ever_locked);
	assign flag_set[`BIT_FREQ_ACQUIRED] = freq_locked;
	// No loss before a phase lock was ever held
	assign flag_set[`BIT_PHASE_LOSS] = !phase_locked &&
		phase_was_locked;
	assign flag_set[`BIT_PHASE_ACQUIRED] = phase_locked;
	// Edge only, so a supply held low raises one event, not a stream
	assign flag_set[`BIT_UNDERVOLTAGE] = undervoltage &&
		!undervoltage_d;

	assign flag_clear[`BIT_ALMOST_FULL] = status_read ||
		data_read_clear;
	assign flag_clear[6] = 1'b0;
	assign flag_clear[`BIT_NEW_SAMPLE] = status_read ||
		data_read_clear;
	assign flag_clear[`BIT_FREQ_LOSS] = status_read;
	assign flag_clear[`BIT_FREQ_ACQUIRED] = status_read;
	assign flag_clear[`BIT_PHASE_LOSS] = status_read;
	assign flag_clear[`BIT_PHASE_ACQUIRED] = status_read;
	assign flag_clear[`BIT_UNDERVOLTAGE] = status_read ||
		shutdown_set;

	// One sticky cell per implemented flag; bit 6 is a hole
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
			if (gi == 6) begin : g_unused
				assign event_flags[gi] = 1'b0;
			end else begin : g_cell
				status_flag_cell #(
					.RESET_VALUE(FLAG_RESET[gi])
				) u_cell (
					.i_clk(i_clk),
					.i_reset_n(i_reset_n),
					.i_set(flag_set[gi]),
					.i_clear(flag_clear[gi]),
					.o_flag(event_flags[gi])
				);
			end
		end
	endgenerate

	// Writable registers; a write to a read-only offset is ignored
	// Shutdown bit is stored here as well as acted on above
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_almost_full_threshold <= `RESET_CONFIG;
			o_fifo_config <= `RESET_CONFIG;
			o_system_config <= `RESET_CONFIG;
			o_impedance_config_3 <= `RESET_CONFIG;
			o_impedance_config_4 <= `RESET_CONFIG;
			o_impedance_config_5 <= `RESET_CONFIG;
			o_impedance_config_6 <= `RESET_CONFIG;
			o_reading_low_limit <= `RESET_CONFIG;
			o_reading_high_limit <= `RESET_CONFIG;
			o_impedance_config_7 <= `RESET_CONFIG;
			o_electrode_switch_config_1 <= `RESET_CONFIG;
			o_electrode_switch_config_2 <= `RESET_CONFIG;
			o_electrode_assignment <= `RESET_CONFIG;
			o_lead_detect_config <= `RESET_CONFIG;
			o_lead_detect_limit <= `RESET_CONFIG;
			o_lead_bias_config <= `RESET_CONFIG;
			o_irq_mask_primary <= `RESET_CONFIG;
			o_irq_mask_secondary <= `RESET_CONFIG;
		end else if (i_reg_write) begin
			case (i_reg_addr)
			`ADDR_FIFO_ALMOST_FULL: o_almost_full_threshold <= i_reg_wdata;
			`ADDR_FIFO_CONFIG_2: o_fifo_config <= i_reg_wdata;
			`ADDR_SYSTEM_CONFIG_1: o_system_config <= i_reg_wdata;
			`ADDR_IMPEDANCE_CONFIG_3: o_impedance_config_3 <= i_reg_wdata;
			`ADDR_IMPEDANCE_CONFIG_4: o_impedance_config_4 <= i_reg_wdata;
			`ADDR_IMPEDANCE_CONFIG_5: o_impedance_config_5 <= i_reg_wdata;
			`ADDR_IMPEDANCE_CONFIG_6: o_impedance_config_6 <= i_reg_wdata;
			`ADDR_READING_LOW_LIMIT: o_reading_low_limit <= i_reg_wdata;
			`ADDR_READING_HIGH_LIMIT: o_reading_high_limit <= i_reg_wdata;
			`ADDR_IMPEDANCE_CONFIG_7: o_impedance_config_7 <= i_reg_wdata;
			`ADDR_ELECTRODE_SWITCH_1: begin
				o_electrode_switch_config_1 <= i_reg_wdata;
			end
			`ADDR_ELECTRODE_SWITCH_2: begin
				o_electrode_switch_config_2 <= i_reg_wdata;
			end
			`ADDR_ELECTRODE_ASSIGNMENT: o_electrode_assignment <= i_reg_wdata;
			`ADDR_LEAD_DETECT_CONFIG: o_lead_detect_config <= i_reg_wdata;
			`ADDR_LEAD_DETECT_LIMIT: o_lead_detect_limit <= i_reg_wdata;
			`ADDR_LEAD_BIAS_CONFIG: o_lead_bias_config <= i_reg_wdata;
			`ADDR_IRQ_MASK_PRIMARY: o_irq_mask_primary <= i_reg_wdata;
			`ADDR_IRQ_MASK_SECONDARY: o_irq_mask_secondary <= i_reg_wdata;
			default: begin
			end
			endcase
		end
	end

	// Read multiplexer; unmapped offsets read zero
	reg [7:0] next_rdata;

	always @* begin
		case (i_reg_addr)
		`ADDR_EVENT_FLAGS_PRIMARY: next_rdata = event_flags &
			`MASK_EVENT_FLAGS;
		`ADDR_FIFO_DATA: next_rdata = i_fifo_rdata;
		`ADDR_FIFO_ALMOST_FULL: next_rdata = o_almost_full_threshold;
		`ADDR_FIFO_CONFIG_2: next_rdata = o_fifo_config;
		`ADDR_SYSTEM_CONFIG_1: next_rdata = o_system_config;
		`ADDR_IMPEDANCE_CONFIG_3: next_rdata = o_impedance_config_3;
		`ADDR_IMPEDANCE_CONFIG_4: next_rdata = o_impedance_config_4;
		`ADDR_IMPEDANCE_CONFIG_5: next_rdata = o_impedance_config_5;
		`ADDR_IMPEDANCE_CONFIG_6: next_rdata = o_impedance_config_6;
		`ADDR_READING_LOW_LIMIT: next_rdata = o_reading_low_limit;
		`ADDR_READING_HIGH_LIMIT: next_rdata = o_reading_high_limit;
		`ADDR_IMPEDANCE_CONFIG_7: next_rdata = o_impedance_config_7;
		`ADDR_ELECTRODE_SWITCH_1: next_rdata = o_electrode_switch_config_1;
		`ADDR_ELECTRODE_SWITCH_2: next_rdata = o_electrode_switch_config_2;
		`ADDR_ELECTRODE_ASSIGNMENT: next_rdata = o_electrode_assignment;
		`ADDR_SELF_TEST_ERROR: next_rdata = test_err;
		`ADDR_LEAD_DETECT_CONFIG: next_rdata = o_lead_detect_config;
		`ADDR_LEAD_DETECT_LIMIT: next_rdata = o_lead_detect_limit;
		`ADDR_LEAD_BIAS_CONFIG: next_rdata = o_lead_bias_config;
		`ADDR_IRQ_MASK_PRIMARY: next_rdata = o_irq_mask_primary;
		`ADDR_IRQ_MASK_SECONDARY: next_rdata = o_irq_mask_secondary;
		`ADDR_DEVICE_IDENTIFIER: next_rdata = DEVICE_ID;
		default: next_rdata = 8'h00;
		endcase
	end

	// Read data registered; captures flags before the clear lands
	// Held between reads so a slow host can fetch it late
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_read) begin
			o_reg_rdata <= next_rdata;
		end
	end

	// Interrupt pin: undervoltage always, others through the masks
	// Bit 0 is dropped from the mask path; undervoltage bypasses it
	// Pin registered so address decode never glitches it
	wire [7:0] masked_primary;
	wire [7:0] masked_secondary;
	assign masked_primary = event_flags & o_irq_mask_primary &
		`MASK_EVENT_FLAGS & 8'hFE;
	assign masked_secondary = sec_flags & o_irq_mask_secondary;

	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_pin <= 1'b0;
		end else begin
			o_irq_pin <= event_flags[`BIT_UNDERVOLTAGE] ||
				(|masked_primary) || (|masked_secondary);
		end
	end

endmodule // status_flag_register_bank

`default_nettype wire

//--- shared/flag_bank_regs.vh
/*
 * Register offsets, field positions and reset values of the
 * status and configuration register bank.
 * Assumes an 8-bit register address and 8-bit data.
 */
`ifndef FLAG_BANK_REGS_VH
`define FLAG_BANK_REGS_VH

// Register offsets
`define ADDR_EVENT_FLAGS_PRIMARY 8'h00
`define ADDR_FIFO_DATA 8'h0C
`define ADDR_FIFO_ALMOST_FULL 8'h0D
`define ADDR_FIFO_CONFIG_2 8'h0E
`define ADDR_SYSTEM_CONFIG_1 8'h11
`define ADDR_IMPEDANCE_CONFIG_3 8'h22
`define ADDR_IMPEDANCE_CONFIG_4 8'h23
`define ADDR_IMPEDANCE_CONFIG_5 8'h24
`define ADDR_IMPEDANCE_CONFIG_6 8'h25
`define ADDR_READING_LOW_LIMIT 8'h26
`define ADDR_READING_HIGH_LIMIT 8'h27
`define ADDR_IMPEDANCE_CONFIG_7 8'h28
`define ADDR_ELECTRODE_SWITCH_1 8'h41
`define ADDR_ELECTRODE_SWITCH_2 8'h42
`define ADDR_ELECTRODE_ASSIGNMENT 8'h43
`define ADDR_SELF_TEST_ERROR 8'h44
`define ADDR_LEAD_DETECT_CONFIG 8'h50
`define ADDR_LEAD_DETECT_LIMIT 8'h51
`define ADDR_LEAD_BIAS_CONFIG 8'h58
`define ADDR_IRQ_MASK_PRIMARY 8'h80
`define ADDR_IRQ_MASK_SECONDARY 8'h81
`define ADDR_DEVICE_IDENTIFIER 8'hFF

// Bit positions in event_flags_primary
`define BIT_ALMOST_FULL 7
`define BIT_NEW_SAMPLE 5
`define BIT_FREQ_LOSS 4
`define BIT_FREQ_ACQUIRED 3
`define BIT_PHASE_LOSS 2
`define BIT_PHASE_ACQUIRED 1
`define BIT_UNDERVOLTAGE 0

// Other field positions
`define BIT_FLAG_CLEAR_ON_DATA_READ 3
`define BIT_SHUTDOWN_CONTROL 1

// Reset values
`define RESET_EVENT_FLAGS 8'h01
`define RESET_CONFIG 8'h00

// Implemented bits of event_flags_primary; bit 6 reads zero
`define MASK_EVENT_FLAGS 8'hBF

`endif
